// ### core/epdrw_core.sv
// Command interpreter for border, user id, RAM window and RAM counters.
// Assumes a mode-0 serial host on link_sclk and a simple register port.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Command 38h stores ten user id bytes
// - Border bits 7:6 pick source, reset C0h
// - Bits 5:4 pick fixed border level
// - Bit 2 picks red-phase transition behaviour
// - Bits 1:0 pick border waveform table
// - Command 44h sets X window, 00h/15h
// - Command 45h sets Y window, 000h/127h
// - Command 4Eh loads X counter
// - Command 4Fh loads Y counter, low first
// - RAM byte advances counter per entry mode
// - Soft restart restores defaults, busy meanwhile
module epdrw_core
    import epdrw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        link_sclk,
    input  wire logic        link_cs_n,
    input  wire logic        link_dc,
    input  wire logic        link_sdi,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output var  logic [31:0] bus_rdata,
    output var  logic        busy,
    output var  logic [7:0]  border_cfg,
    output var  logic [5:0]  window_x_start,
    output var  logic [5:0]  window_x_end,
    output var  logic [8:0]  window_y_start,
    output var  logic [8:0]  window_y_end,
    output var  logic [5:0]  ram_x,
    output var  logic [8:0]  ram_y,
    output var  logic        ram_we,
    output var  logic [5:0]  ram_wx,
    output var  logic [8:0]  ram_wy,
    output var  logic [7:0]  ram_wdata
);

    ////////////////////////////////////////////////////////////////////////
    // Link side: shift bytes in on link_sclk
    logic [2:0]  bit_cnt;
    logic [6:0]  shift;
    epdrw_byte_t link_byte;
    logic        link_tog;

    always_ff @(posedge link_sclk or posedge link_cs_n)
    begin
        if (link_cs_n)
        begin
            bit_cnt <= 3'h0;
            shift   <= 7'h00;
        end
        else
        begin
            bit_cnt <= bit_cnt + 3'h1;
            shift   <= {shift[5:0], link_sdi};
        end
    end

    always_ff @(posedge link_sclk or posedge rst)
    begin
        if (rst)
        begin
            link_byte <= '0;
            link_tog  <= 1'b0;
        end
        else if (!link_cs_n && bit_cnt == 3'h7)
        begin
            link_byte <= '{dc: link_dc, data: {shift, link_sdi}};
            link_tog  <= ~link_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing: toggle synchroniser, byte is stable once the toggle lands
    logic        tog_s1;
    logic        tog_s2;
    logic        tog_s3;
    logic        rx_v;
    epdrw_byte_t rx;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            rx_v   <= 1'b0;
            rx     <= '0;
        end
        else
        begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            rx_v   <= tog_s2 ^ tog_s3;
            if (tog_s2 ^ tog_s3)
                rx <= link_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command tracking
    logic [7:0] cmd;
    logic [3:0] idx;
    logic       accept;
    logic       par;
    logic       restart_go;

    assign accept     = rx_v && !busy;
    assign par        = accept && rx.dc;
    assign restart_go = (accept && !rx.dc && rx.data == CMD_RESTART) ||
                        (bus_wr && bus_addr == OFF_CTRL && bus_wdata[0]);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd <= 8'h00;
            idx <= 4'h0;
        end
        else if (accept && !rx.dc)
        begin
            cmd <= rx.data;
            idx <= 4'h0;
        end
        else if (par && idx != 4'hf)
            idx <= idx + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft restart timer
    logic [4:0] restart_cnt;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            restart_cnt <= 5'h00;
            busy        <= 1'b0;
        end
        else if (restart_go)
        begin
            restart_cnt <= RESTART_CYCLES;
            busy        <= 1'b1;
        end
        else if (restart_cnt != 5'h00)
        begin
            restart_cnt <= restart_cnt - 5'h1;
            busy        <= restart_cnt != 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User id and border settings
    logic [7:0] user_id [USER_ID_BYTES];
    logic [2:0] entry;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < USER_ID_BYTES; i++)
                user_id[i] <= 8'h00;
        end
        else if (restart_go)
        begin
            for (int i = 0; i < USER_ID_BYTES; i++)
                user_id[i] <= 8'h00;
        end
        else if (par && cmd == CMD_USER_ID && idx < 4'(USER_ID_BYTES))
            user_id[idx] <= rx.data;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            border_cfg <= BORDER_RST;
            entry      <= ENTRY_RST;
        end
        else if (restart_go)
        begin
            border_cfg <= BORDER_RST;
            entry      <= ENTRY_RST;
        end
        else if (par && idx == 4'h0)
        begin
            // Source, fixed level, red-phase mode and table in one byte
            if (cmd == CMD_BORDER)
                border_cfg <= rx.data & BORDER_MASK;
            if (cmd == CMD_ENTRY)
                entry <= rx.data[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window limits
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            window_x_start <= WIN_XS_RST;
            window_x_end   <= WIN_XE_RST;
            window_y_start <= WIN_YS_RST;
            window_y_end   <= WIN_YE_RST;
        end
        else if (restart_go)
        begin
            window_x_start <= WIN_XS_RST;
            window_x_end   <= WIN_XE_RST;
            window_y_start <= WIN_YS_RST;
            window_y_end   <= WIN_YE_RST;
        end
        else if (par && cmd == CMD_WIN_X)
        begin
            if (idx == 4'h0)
                window_x_start <= rx.data[5:0];
            if (idx == 4'h1)
                window_x_end <= rx.data[5:0];
        end
        else if (par && cmd == CMD_WIN_Y)
        begin
            case (idx)
                4'h0: window_y_start[7:0] <= rx.data;
                4'h1: window_y_start[8]   <= rx.data[0];
                4'h2: window_y_end[7:0]   <= rx.data;
                4'h3: window_y_end[8]     <= rx.data[0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address counters and RAM write port
    function automatic logic [9:0] step(input logic [8:0] cur,
                                        input logic [8:0] lo,
                                        input logic [8:0] hi,
                                        input logic       inc);
        logic wrap;
        wrap = inc ? (cur == hi) : (cur == lo);
        if (wrap)
            step = {1'b1, inc ? lo : hi};
        else
            step = {1'b0, inc ? cur + 9'h1 : cur - 9'h1};
    endfunction

    logic       ram_go;
    logic [9:0] sx;
    logic [9:0] sy;

    assign ram_go = par && (cmd == CMD_RAM_BW || cmd == CMD_RAM_RED);
    assign sx = step({3'h0, ram_x}, {3'h0, window_x_start},
                     {3'h0, window_x_end}, entry[ENTRY_XINC_BIT]);
    assign sy = step(ram_y, window_y_start, window_y_end,
                     entry[ENTRY_YINC_BIT]);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ram_x <= CNT_X_RST;
            ram_y <= CNT_Y_RST;
        end
        else if (restart_go)
        begin
            ram_x <= CNT_X_RST;
            ram_y <= CNT_Y_RST;
        end
        else if (par && cmd == CMD_CNT_X && idx == 4'h0)
            ram_x <= rx.data[5:0];
        else if (par && cmd == CMD_CNT_Y && idx == 4'h0)
            ram_y[7:0] <= rx.data;
        else if (par && cmd == CMD_CNT_Y && idx == 4'h1)
            ram_y[8] <= rx.data[0];
        else if (ram_go)
        begin
            // Primary axis steps; wrapping it carries into the other
            if (!entry[ENTRY_AXIS_BIT])
            begin
                ram_x <= sx[5:0];
                if (sx[9])
                    ram_y <= sy[8:0];
            end
            else
            begin
                ram_y <= sy[8:0];
                if (sy[9])
                    ram_x <= sx[5:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ram_we    <= 1'b0;
            ram_wx    <= 6'h00;
            ram_wy    <= 9'h000;
            ram_wdata <= 8'h00;
        end
        else
        begin
            ram_we <= ram_go;
            if (ram_go)
            begin
                ram_wx    <= ram_x;
                ram_wy    <= ram_y;
                ram_wdata <= rx.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bus_rdata <= 32'h0;
        else if (!bus_rd)
            bus_rdata <= 32'h0;
        else
        begin
            case (bus_addr)
                OFF_CTRL:   bus_rdata <= {31'h0, busy};
                OFF_BORDER: bus_rdata <= {24'h0, border_cfg};
                OFF_WIN_X:  bus_rdata <= {18'h0, window_x_end, 2'h0,
                                          window_x_start};
                OFF_WIN_Y:  bus_rdata <= {7'h0, window_y_end, 7'h0,
                                          window_y_start};
                OFF_CNT:    bus_rdata <= {7'h0, ram_y, 10'h0, ram_x};
                OFF_ENTRY:  bus_rdata <= {29'h0, entry};
                default:
                begin
                    bus_rdata <= 32'h0;
                    for (int i = 0; i < USER_ID_BYTES; i++)
                        if (bus_addr == OFF_UID + 8'(4 * i))
                            bus_rdata <= {24'h0, user_id[i]};
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence param_to(logic [7:0] c, logic [3:0] n);
        par && cmd == c && idx == n && !restart_go;
    endsequence

    uid_store_a: assert property (
        param_to(CMD_USER_ID, 4'h3) |=> user_id[3] == $past(rx.data))
        else $error("user id byte not stored");
    border_src_a: assert property (
        param_to(CMD_BORDER, 4'h0) |=>
            border_cfg[7:4] == $past(rx.data[7:4]) &&
            border_cfg[2:0] == $past(rx.data[2:0]))
        else $error("border setting not taken");
    border_pad_a: assert property (border_cfg[3] == 1'b0)
        else $error("unused border bit set");
    win_x_a: assert property (
        param_to(CMD_WIN_X, 4'h1) |=> window_x_end == $past(rx.data[5:0]))
        else $error("x window end wrong");
    win_y_a: assert property (
        param_to(CMD_WIN_Y, 4'h1) |=>
            window_y_start[8] == $past(rx.data[0]) &&
            $stable(window_y_start[7:0]))
        else $error("y window start high bit wrong");
    cnt_load_a: assert property (
        param_to(CMD_CNT_X, 4'h0) |=> ram_x == $past(rx.data[5:0]))
        else $error("x counter not loaded");
    cnt_y_a: assert property (
        param_to(CMD_CNT_Y, 4'h1) |=> ram_y[8] == $past(rx.data[0]))
        else $error("y counter high bit wrong");
    ram_step_a: assert property (
        ram_go && !restart_go && entry == 3'h3 &&
        ram_x != window_x_end |=> ram_x == $past(ram_x) + 6'h1 && ram_we)
        else $error("x counter did not advance");
    restart_a: assert property (
        restart_go |=> busy [*8] ##0 border_cfg == BORDER_RST)
        else $error("soft restart not held busy");
    cmd_track_a: assert property (
        accept && !rx.dc |=> cmd == $past(rx.data) && idx == 4'h0)
        else $error("command byte not tracked");

endmodule

`default_nettype wire

// ### shared/epdrw_pkg.sv
// Shared constants and types for the e-paper window and border commands.
// Assumes a 20 MHz ref_clk and a byte-oriented host link.
package epdrw_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int unsigned REF_CLK_NS = 50;
    localparam int unsigned RESTART_NS = 800;
    localparam logic [4:0]  RESTART_CYCLES =
        5'((RESTART_NS + REF_CLK_NS - 1) / REF_CLK_NS);

    localparam logic [7:0] CMD_ENTRY   = 8'h11;
    localparam logic [7:0] CMD_RESTART = 8'h12;
    localparam logic [7:0] CMD_RAM_BW  = 8'h24;
    localparam logic [7:0] CMD_RAM_RED = 8'h26;
    localparam logic [7:0] CMD_USER_ID = 8'h38;
    localparam logic [7:0] CMD_BORDER  = 8'h3c;
    localparam logic [7:0] CMD_WIN_X   = 8'h44;
    localparam logic [7:0] CMD_WIN_Y   = 8'h45;
    localparam logic [7:0] CMD_CNT_X   = 8'h4e;
    localparam logic [7:0] CMD_CNT_Y   = 8'h4f;

    localparam int unsigned USER_ID_BYTES = 10;

    localparam logic [7:0] BORDER_RST  = 8'hc0;
    localparam logic [7:0] BORDER_MASK = 8'hf7;
    localparam logic [5:0] WIN_XS_RST  = 6'h00;
    localparam logic [5:0] WIN_XE_RST  = 6'h15;
    localparam logic [8:0] WIN_YS_RST  = 9'h000;
    localparam logic [8:0] WIN_YE_RST  = 9'h127;
    localparam logic [5:0] CNT_X_RST   = 6'h00;
    localparam logic [8:0] CNT_Y_RST   = 9'h000;
    localparam logic [2:0] ENTRY_RST   = 3'h3;

    localparam int unsigned ENTRY_AXIS_BIT = 2;
    localparam int unsigned ENTRY_YINC_BIT = 1;
    localparam int unsigned ENTRY_XINC_BIT = 0;

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_BORDER = 8'h04;
    localparam logic [7:0] OFF_WIN_X  = 8'h08;
    localparam logic [7:0] OFF_WIN_Y  = 8'h0c;
    localparam logic [7:0] OFF_CNT    = 8'h10;
    localparam logic [7:0] OFF_ENTRY  = 8'h14;
    localparam logic [7:0] OFF_UID    = 8'h20;

    typedef struct packed {
        logic       dc;
        logic [7:0] data;
    } epdrw_byte_t;

endpackage

// ### dv/epdrw_host.sv
// Host side of the serial link: sends command and parameter bytes.
// Assumes mode 0, MSB first, link clock still between frames.
`timescale 1ns/1ps
`default_nettype none

module epdrw_host
    import epdrw_pkg::*;
(
    output var logic link_sclk,
    output var logic link_cs_n,
    output var logic link_dc,
    output var logic link_sdi
);

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_dc   = 1'b1;
        link_sdi  = 1'b0;
    end

    // One byte per frame; 48 ns link clock
    task automatic send_byte(input epdrw_byte_t b);
        int i;
        link_cs_n = 1'b0;
        link_dc   = b.dc;
        #40;
        for (i = 7; i >= 0; i--)
        begin
            link_sdi  = b.data[i];
            #24 link_sclk = 1'b1;
            #24 link_sclk = 1'b0;
        end
        #70 link_cs_n = 1'b1;
        // Released lines show no stale value
        link_sdi = ~link_sdi;
        link_dc  = ~link_dc;
        #110;
    endtask

endmodule

`default_nettype wire

// ### dv/tb.sv
// Testbench for the window, border, user id and counter commands.
// Assumes the host model drives the link and the bench the register port.
`timescale 1ns/1ps
`default_nettype none

module tb
    import epdrw_pkg::*;
;
    logic        ref_clk;
    logic        rst;
    logic        link_sclk;
    logic        link_cs_n;
    logic        link_dc;
    logic        link_sdi;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [31:0] bus_rdata;
    logic        busy;
    logic [7:0]  border_cfg;
    logic [5:0]  window_x_start;
    logic [5:0]  window_x_end;
    logic [8:0]  window_y_start;
    logic [8:0]  window_y_end;
    logic [5:0]  ram_x;
    logic [8:0]  ram_y;
    logic        ram_we;
    logic [5:0]  ram_wx;
    logic [8:0]  ram_wy;
    logic [7:0]  ram_wdata;
    logic [22:0] last_w;
    int          wcount;
    int          fails;
    int          checks;
    logic [31:0] rd;

    epdrw_core epdrw_core_i (.ref_clk(ref_clk), .rst(rst),
        .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_dc(link_dc),
        .link_sdi(link_sdi), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .busy(busy), .border_cfg(border_cfg),
        .window_x_start(window_x_start), .window_x_end(window_x_end),
        .window_y_start(window_y_start), .window_y_end(window_y_end),
        .ram_x(ram_x), .ram_y(ram_y), .ram_we(ram_we), .ram_wx(ram_wx),
        .ram_wy(ram_wy), .ram_wdata(ram_wdata));

    epdrw_host epdrw_host_i (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_dc(link_dc), .link_sdi(link_sdi));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (ram_we === 1'b1)
        begin
            wcount++;
            last_w <= {ram_wy, ram_wx, ram_wdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge ref_clk);
        bus_wr    <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge ref_clk);
        bus_rd   <= 1'b0;
        @(negedge ref_clk);
        d = bus_rdata;
    endtask

    task automatic send_cmd(input logic [7:0] op, input logic [7:0] p[$]);
        epdrw_host_i.send_byte('{dc: 1'b0, data: op});
        foreach (p[i])
            epdrw_host_i.send_byte('{dc: 1'b1, data: p[i]});
        repeat (8) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        check(border_cfg, 32'h0000_00c0);
        check({window_x_end, window_x_start}, 32'h0000_0540);
        check({window_y_end, window_y_start}, 32'h0002_4e00);
        check(ram_x, 32'h0);
        check(ram_y, 32'h0);
        bus_read(8'hfc, rd);
        check(rd, 32'h0);
    endtask

    task automatic t_border();
        logic [7:0] v[10] = '{8'h0c, 8'h01, 8'h06, 8'h0b, 8'h40,
                              8'h58, 8'h60, 8'h70, 8'h80, 8'hcf};
        foreach (v[i])
        begin
            send_cmd(CMD_BORDER, '{v[i]});
            check(border_cfg, v[i] & 8'hf7);
        end
        bus_read(OFF_BORDER, rd);
        check(rd, 32'h0000_00c7);
    endtask

    task automatic t_user_id();
        int i;
        send_cmd(CMD_USER_ID, '{8'h10, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65,
                                8'h76, 8'h87, 8'h98, 8'ha9});
        for (i = 0; i < 10; i++)
        begin
            bus_read(8'(OFF_UID + 4 * i), rd);
            check(rd, 32'(8'h10 + 8'h11 * i));
        end
    endtask

    task automatic t_window_counter();
        send_cmd(CMD_WIN_X, '{8'hc5, 8'hff});
        check({window_x_end, window_x_start}, 32'h0000_0fc5);
        send_cmd(CMD_WIN_Y, '{8'h34, 8'hff, 8'h12, 8'h00});
        check({window_y_end, window_y_start}, 32'h0000_2534);
        send_cmd(CMD_CNT_X, '{8'hea});
        check(ram_x, 32'h2a);
        send_cmd(CMD_CNT_Y, '{8'h99, 8'h03});
        check(ram_y, 32'h199);
    endtask

    task automatic t_ram_advance();
        int n;
        send_cmd(CMD_WIN_X, '{8'h00, 8'h01});
        send_cmd(CMD_WIN_Y, '{8'h00, 8'h00, 8'h02, 8'h00});
        send_cmd(CMD_CNT_X, '{8'h00});
        send_cmd(CMD_CNT_Y, '{8'h00, 8'h00});
        send_cmd(CMD_ENTRY, '{8'h03});
        n = wcount;
        send_cmd(CMD_RAM_BW, '{8'ha1, 8'hb2, 8'hc3});
        check(wcount - n, 32'd3);
        check(last_w, {9'h001, 6'h00, 8'hc3});
        check({ram_y, ram_x}, {9'h001, 6'h01});
        // Y axis first, both axes counting down, wrap carries into X
        send_cmd(CMD_CNT_X, '{8'h00});
        send_cmd(CMD_CNT_Y, '{8'h00, 8'h00});
        send_cmd(CMD_ENTRY, '{8'h04});
        n = wcount;
        send_cmd(CMD_RAM_RED, '{8'hd4, 8'he5});
        check(wcount - n, 32'd2);
        check(last_w, {9'h002, 6'h01, 8'he5});
        check({ram_y, ram_x}, {9'h001, 6'h01});
        bus_read(OFF_ENTRY, rd);
        check(rd, 32'h0000_0004);
        bus_read(OFF_CNT, rd);
        check(rd, 32'h0001_0001);
    endtask

    task automatic t_restart();
        int n;
        epdrw_host_i.send_byte('{dc: 1'b0, data: CMD_RESTART});
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(busy, 32'h1);
        bus_read(OFF_CTRL, rd);
        check(rd, 32'h1);
        repeat (30) @(posedge ref_clk);
        check(busy, 32'h0);
        check(border_cfg, 32'h0000_00c0);
        check({window_x_end, window_x_start}, 32'h0000_0540);
        check({window_y_end, window_y_start}, 32'h0002_4e00);
        check({ram_y, ram_x}, 32'h0);
        bus_read(OFF_ENTRY, rd);
        check(rd, 32'h0000_0003);
        bus_read(OFF_UID, rd);
        check(rd, 32'h0);
        bus_write(OFF_CTRL, 32'h1);
        @(negedge ref_clk);
        check(busy, 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst       = 1'b1;
        bus_addr  = 8'h00;
        bus_wdata = 32'h0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        wcount    = 0;
        fails     = 0;
        checks    = 0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_values();
        t_border();
        t_user_id();
        t_window_counter();
        t_ram_advance();
        t_restart();
        tally_and_finish();
    end

    initial
    begin
        #400us;
        fails++;
        tally_and_finish();
    end

endmodule

`default_nettype wire
